// ### km_keying_mixer.sv
// Purpose: keying mixer, data stream keyed onto two carriers
// Assumes: one clock, synchronous active-low reset, AXI4-Lite
// Notes:   carrier edges are seen after the input synchronisers
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - data high picks upper, low picks lower
// - keyed result of carrier and data drives pin
// - enable bit starts the mixer
// - disabled: carriers ground, data software bit
// - selections kept while disabled, reused later
// - pin held low while disabled
// - data source chosen by four-bit field
// - upper carrier chosen by four-bit field
// - lower carrier chosen by four-bit field
// - thirteen data stream sources offered
// - thirteen carrier sources offered per carrier
// - serial data out valid only in SPI
// - leaving synced carrier: hold until falling edge
// - returning synced carrier: wait for falling edge
// - upper sync bit enables upper synchronisation
// - lower sync bit enables lower synchronisation
// - upper invert bit inverts upper carrier
// - lower invert bit inverts lower carrier
// - output invert bit inverts pin
// - reset disables mixer, registers to default
module km_keying_mixer
  import km_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        captureCompareOne,
  input  wire logic        captureCompareTwo,
  input  wire logic        pulseGeneratorFive,
  input  wire logic        pulseGeneratorSix,
  input  wire logic        serialPortOneDataOut,
  input  wire logic        serialPortOneSpiMode,
  input  wire logic        comparatorOne,
  input  wire logic        comparatorTwo,
  input  wire logic        uartTransmitter,
  input  wire logic        externalDataPin,
  input  wire logic        numericOscillator,
  input  wire logic        logicCellOne,
  input  wire logic        logicCellTwo,
  input  wire logic        fastInternalOscillator,
  input  wire logic        referenceClock,
  input  wire logic        externalCarrierPinA,
  input  wire logic        externalCarrierPinB,
  output logic             keyedOutput
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [IN_NUM-1:0] syncA;
    logic [IN_NUM-1:0] syncB;
    logic              sysClkDiv;
    logic              upperPrev;
    logic              lowerPrev;
    logic              upperAct;
    logic              lowerAct;
    logic              keyed;
    logic [7:0]        ctl;
    logic [7:0]        src;
    logic [7:0]        upper_carrier;
    logic [7:0]        lower_carrier;
    logic              awHave;
    logic [7:0]        awAddr;
    logic              wHave;
    logic [7:0]        wData;
    logic              wLane;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
  } km_state_t;

  km_state_t st_ff;
  km_state_t nxt_st;

  logic [IN_NUM-1:0] rawIn;
  logic [IN_NUM-1:0] inS;
  logic              enable;
  logic              dataBit;
  logic              upperRaw;
  logic              lowerRaw;
  logic              upperCar;
  logic              lowerCar;
  logic              upperFall;
  logic              lowerFall;
  logic              upperNext;
  logic              lowerNext;
  logic              mixed;
  logic              doWrite;
  logic              addrOk;

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  function automatic logic pick_data(
    input logic [3:0]        sel,
    input logic [IN_NUM-1:0] v,
    input logic              sw
  );
    logic r;
    r = 1'b0;
    case (sel)
      DS_SOFT: r = sw;
      DS_CAPTURE_COMPARE_ONE: r = v[IN_CAPTURE_COMPARE_ONE];
      DS_CAPTURE_COMPARE_TWO: r = v[IN_CAPTURE_COMPARE_TWO];
      DS_PULSE_GENERATOR_FIVE: r = v[IN_PULSE_GENERATOR_FIVE];
      DS_PULSE_GENERATOR_SIX: r = v[IN_PULSE_GENERATOR_SIX];
      DS_SDO:  r = v[IN_SDO] & v[IN_SPIM];
      DS_CMP1: r = v[IN_CMP1];
      DS_CMP2: r = v[IN_CMP2];
      DS_UART: r = v[IN_UART];
      DS_PIN:  r = v[IN_DPIN];
      DS_NCO:  r = v[IN_NCO];
      DS_LOGIC_CELL_ONE: r = v[IN_LOGIC_CELL_ONE];
      DS_LOGIC_CELL_TWO: r = v[IN_LOGIC_CELL_TWO];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_data

  function automatic logic pick_carrier(
    input logic [3:0]        sel,
    input logic [IN_NUM-1:0] v,
    input logic              sck
  );
    logic r;
    r = 1'b0;
    case (sel)
      CS_GND:   r = 1'b0;
      CS_CAPTURE_COMPARE_ONE:  r = v[IN_CAPTURE_COMPARE_ONE];
      CS_CAPTURE_COMPARE_TWO:  r = v[IN_CAPTURE_COMPARE_TWO];
      CS_PULSE_GENERATOR_FIVE:  r = v[IN_PULSE_GENERATOR_FIVE];
      CS_PULSE_GENERATOR_SIX:  r = v[IN_PULSE_GENERATOR_SIX];
      CS_NCO:   r = v[IN_NCO];
      CS_SYSCK: r = sck;
      CS_FOSC:  r = v[IN_FOSC];
      CS_LOGIC_CELL_ONE:  r = v[IN_LOGIC_CELL_ONE];
      CS_LOGIC_CELL_TWO:  r = v[IN_LOGIC_CELL_TWO];
      CS_REFCK: r = v[IN_REFC];
      CS_PINA:  r = v[IN_PINA];
      CS_PINB:  r = v[IN_PINB];
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : pick_carrier

  // ---------------------------------------------------------------
  // raw input vector
  // ---------------------------------------------------------------
  always_comb begin
    rawIn          = '0;
    rawIn[IN_CAPTURE_COMPARE_ONE] = captureCompareOne;
    rawIn[IN_CAPTURE_COMPARE_TWO] = captureCompareTwo;
    rawIn[IN_PULSE_GENERATOR_FIVE] = pulseGeneratorFive;
    rawIn[IN_PULSE_GENERATOR_SIX] = pulseGeneratorSix;
    rawIn[IN_SDO]  = serialPortOneDataOut;
    rawIn[IN_SPIM] = serialPortOneSpiMode;
    rawIn[IN_CMP1] = comparatorOne;
    rawIn[IN_CMP2] = comparatorTwo;
    rawIn[IN_UART] = uartTransmitter;
    rawIn[IN_DPIN] = externalDataPin;
    rawIn[IN_NCO]  = numericOscillator;
    rawIn[IN_LOGIC_CELL_ONE] = logicCellOne;
    rawIn[IN_LOGIC_CELL_TWO] = logicCellTwo;
    rawIn[IN_FOSC] = fastInternalOscillator;
    rawIn[IN_REFC] = referenceClock;
    rawIn[IN_PINA] = externalCarrierPinA;
    rawIn[IN_PINB] = externalCarrierPinB;
  end

  // ---------------------------------------------------------------
  // mixing datapath
  // ---------------------------------------------------------------
  always_comb begin
    inS     = st_ff.syncB;
    enable  = st_ff.ctl[CTL_ENABLE_BIT];
    dataBit = pick_data(enable ? st_ff.src[3:0] : DS_SOFT,
                        inS, st_ff.ctl[CTL_SWBIT_BIT]);
    upperRaw = pick_carrier(enable ? st_ff.upper_carrier[3:0] : CS_GND,
                            inS, st_ff.sysClkDiv);
    lowerRaw = pick_carrier(enable ? st_ff.lower_carrier[3:0] : CS_GND,
                            inS, st_ff.sysClkDiv);
    upperCar  = upperRaw ^ st_ff.upper_carrier[CAR_INVERT_BIT];
    lowerCar  = lowerRaw ^ st_ff.lower_carrier[CAR_INVERT_BIT];
    upperFall = st_ff.upperPrev & ~upperCar;
    lowerFall = st_ff.lowerPrev & ~lowerCar;
    upperNext = st_ff.upperAct;
    lowerNext = st_ff.lowerAct;
    if (!st_ff.upper_carrier[CAR_SYNC_BIT]) begin
      upperNext = dataBit;
    end else if (upperFall) begin
      upperNext = dataBit;
    end
    if (!st_ff.lower_carrier[CAR_SYNC_BIT]) begin
      lowerNext = ~dataBit;
    end else if (lowerFall) begin
      lowerNext = ~dataBit;
    end
    mixed = (upperNext & upperCar) | (lowerNext & lowerCar);
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    awready = !st_ff.awHave && !st_ff.bValid;
    wready  = !st_ff.wHave && !st_ff.bValid;
    arready = !st_ff.rValid;
    bvalid  = st_ff.bValid;
    bresp   = st_ff.bResp;
    rvalid  = st_ff.rValid;
    rdata   = st_ff.rData;
    rresp   = st_ff.rResp;
    doWrite = st_ff.awHave && st_ff.wHave && !st_ff.bValid;
    if (st_ff.awAddr == MIXER_CONTROL_OFS) begin
      addrOk = 1'b1;
    end else if (st_ff.awAddr == DATA_SOURCE_OFS) begin
      addrOk = 1'b1;
    end else if (st_ff.awAddr == UPPER_CARRIER_OFS) begin
      addrOk = 1'b1;
    end else if (st_ff.awAddr == LOWER_CARRIER_OFS) begin
      addrOk = 1'b1;
    end else begin
      addrOk = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.syncA     = rawIn;
    nxt_st.syncB     = st_ff.syncA;
    nxt_st.sysClkDiv = ~st_ff.sysClkDiv;
    nxt_st.upperPrev = upperCar;
    nxt_st.lowerPrev = lowerCar;
    nxt_st.upperAct  = upperNext;
    nxt_st.lowerAct  = lowerNext;
    nxt_st.keyed     = enable & (mixed ^ st_ff.ctl[CTL_OINV_BIT]);
    nxt_st.ctl[CTL_OUT_BIT] = st_ff.keyed;
    if (awvalid && awready) begin
      nxt_st.awHave = 1'b1;
      nxt_st.awAddr = {awaddr[7:2], 2'b00};
    end
    if (wvalid && wready) begin
      nxt_st.wHave = 1'b1;
      nxt_st.wData = wdata[7:0];
      nxt_st.wLane = wstrb[0];
    end
    if (doWrite) begin
      nxt_st.awHave = 1'b0;
      nxt_st.wHave  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = addrOk ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.wLane) begin
        if (st_ff.awAddr == MIXER_CONTROL_OFS) begin
          nxt_st.ctl[CTL_ENABLE_BIT] = st_ff.wData[CTL_ENABLE_BIT];
          nxt_st.ctl[CTL_OINV_BIT]   = st_ff.wData[CTL_OINV_BIT];
          nxt_st.ctl[CTL_SWBIT_BIT]  = st_ff.wData[CTL_SWBIT_BIT];
        end else if (st_ff.awAddr == DATA_SOURCE_OFS) begin
          nxt_st.src = {4'h0, st_ff.wData[3:0]};
        end else if (st_ff.awAddr == UPPER_CARRIER_OFS) begin
          nxt_st.upper_carrier = {1'b0, st_ff.wData[6:5], 1'b0,
                         st_ff.wData[3:0]};
        end else if (st_ff.awAddr == LOWER_CARRIER_OFS) begin
          nxt_st.lower_carrier = {1'b0, st_ff.wData[6:5], 1'b0,
                         st_ff.wData[3:0]};
        end
      end
    end
    if (st_ff.bValid && bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp  = RESP_OKAY;
      if ({araddr[7:2], 2'b00} == MIXER_CONTROL_OFS) begin
        nxt_st.rData = {24'h000000, st_ff.ctl[7:4], st_ff.keyed,
                        st_ff.ctl[2:0]};
      end else if ({araddr[7:2], 2'b00} == DATA_SOURCE_OFS) begin
        nxt_st.rData = {24'h000000, st_ff.src};
      end else if ({araddr[7:2], 2'b00} == UPPER_CARRIER_OFS) begin
        nxt_st.rData = {24'h000000, st_ff.upper_carrier};
      end else if ({araddr[7:2], 2'b00} == LOWER_CARRIER_OFS) begin
        nxt_st.rData = {24'h000000, st_ff.lower_carrier};
      end else begin
        nxt_st.rData = 32'h00000000;
        nxt_st.rResp = RESP_SLVERR;
      end
    end else if (st_ff.rValid && rready) begin
      nxt_st.rValid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_ff      <= '0;
      st_ff.ctl  <= CTL_RESET;
      st_ff.src  <= SRC_RESET;
      st_ff.upper_carrier <= CAR_RESET;
      st_ff.lower_carrier <= CAR_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign keyedOutput = st_ff.keyed;

endmodule : km_keying_mixer
`default_nettype wire

// ### km_pkg.sv
// Purpose: constants for the keying mixer
// Assumes: 32-bit AXI4-Lite register access
// Notes:   source codes, offsets and field positions
`default_nettype none
package km_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] MIXER_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] DATA_SOURCE_OFS    = 8'h04;
  localparam logic [7:0] UPPER_CARRIER_OFS  = 8'h08;
  localparam logic [7:0] LOWER_CARRIER_OFS  = 8'h0C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_ENABLE_BIT  = 7;
  localparam int CTL_OINV_BIT    = 4;
  localparam int CTL_OUT_BIT     = 3;
  localparam int CTL_SWBIT_BIT   = 0;
  localparam int CAR_INVERT_BIT  = 6;
  localparam int CAR_SYNC_BIT    = 5;
  localparam int SEL_WIDTH       = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [7:0] CAR_RESET = 8'h00;
  // ---------------------------------------------------------------
  // data stream source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] DS_SOFT  = 4'h0;
  localparam logic [3:0] DS_CAPTURE_COMPARE_ONE  = 4'h1;
  localparam logic [3:0] DS_CAPTURE_COMPARE_TWO  = 4'h2;
  localparam logic [3:0] DS_PULSE_GENERATOR_FIVE  = 4'h3;
  localparam logic [3:0] DS_PULSE_GENERATOR_SIX  = 4'h4;
  localparam logic [3:0] DS_SDO   = 4'h5;
  localparam logic [3:0] DS_CMP1  = 4'h6;
  localparam logic [3:0] DS_CMP2  = 4'h7;
  localparam logic [3:0] DS_UART  = 4'h8;
  localparam logic [3:0] DS_PIN   = 4'h9;
  localparam logic [3:0] DS_NCO   = 4'hA;
  localparam logic [3:0] DS_LOGIC_CELL_ONE  = 4'hB;
  localparam logic [3:0] DS_LOGIC_CELL_TWO  = 4'hC;
  // ---------------------------------------------------------------
  // carrier source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CS_GND   = 4'h0;
  localparam logic [3:0] CS_CAPTURE_COMPARE_ONE  = 4'h1;
  localparam logic [3:0] CS_CAPTURE_COMPARE_TWO  = 4'h2;
  localparam logic [3:0] CS_PULSE_GENERATOR_FIVE  = 4'h3;
  localparam logic [3:0] CS_PULSE_GENERATOR_SIX  = 4'h4;
  localparam logic [3:0] CS_NCO   = 4'h5;
  localparam logic [3:0] CS_SYSCK = 4'h6;
  localparam logic [3:0] CS_FOSC  = 4'h7;
  localparam logic [3:0] CS_LOGIC_CELL_ONE  = 4'h8;
  localparam logic [3:0] CS_LOGIC_CELL_TWO  = 4'h9;
  localparam logic [3:0] CS_REFCK = 4'hA;
  localparam logic [3:0] CS_PINA  = 4'hB;
  localparam logic [3:0] CS_PINB  = 4'hC;
  // ---------------------------------------------------------------
  // synchronised input vector positions
  // ---------------------------------------------------------------
  localparam int IN_CAPTURE_COMPARE_ONE = 0;
  localparam int IN_CAPTURE_COMPARE_TWO = 1;
  localparam int IN_PULSE_GENERATOR_FIVE = 2;
  localparam int IN_PULSE_GENERATOR_SIX = 3;
  localparam int IN_SDO  = 4;
  localparam int IN_SPIM = 5;
  localparam int IN_CMP1 = 6;
  localparam int IN_CMP2 = 7;
  localparam int IN_UART = 8;
  localparam int IN_DPIN = 9;
  localparam int IN_NCO  = 10;
  localparam int IN_LOGIC_CELL_ONE = 11;
  localparam int IN_LOGIC_CELL_TWO = 12;
  localparam int IN_FOSC = 13;
  localparam int IN_REFC = 14;
  localparam int IN_PINA = 15;
  localparam int IN_PINB = 16;
  localparam int IN_NUM  = 17;
  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : km_pkg
`default_nettype wire

// ### km_properties.sv
// Purpose: bus and pin properties of the keying mixer
// Assumes: bound to km_keying_mixer, single clock domain
// Notes:   watches top-level ports only
`timescale 1ns/1ps
`default_nettype none
module km_properties (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        keyedOutput
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence s_readTaken;
    arvalid && arready;
  endsequence
  sequence s_writeTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  property p_readAnswer;
    s_readTaken |=> ##[0:1] rvalid;
  endproperty
  property p_writeAnswer;
    s_writeTaken |=> ##[0:2] bvalid;
  endproperty
  property p_bHold;
    bvalid && !bready |=> bvalid;
  endproperty
  property p_bDrop;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_rHold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  property p_arBlock;
    rvalid |-> !arready;
  endproperty
  property p_awBlock;
    bvalid |-> !awready && !wready;
  endproperty
  property p_rdataHigh;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  property p_resetIdle;
    disable iff (1'h0) !reset_n |=> !bvalid && !rvalid && !keyedOutput;
  endproperty
  a_readAnswer: assert property (p_readAnswer)
    else $error("read not answered");
  a_writeAnswer: assert property (p_writeAnswer)
    else $error("write not answered");
  a_bHold: assert property (p_bHold)
    else $error("write response dropped early");
  a_bDrop: assert property (p_bDrop)
    else $error("write response not released");
  a_rHold: assert property (p_rHold)
    else $error("read data not held");
  a_arBlock: assert property (p_arBlock)
    else $error("read address taken while busy");
  a_awBlock: assert property (p_awBlock)
    else $error("write taken while response pending");
  a_rdataHigh: assert property (p_rdataHigh)
    else $error("read data upper bits not zero");
  a_resetIdle: assert property (p_resetIdle)
    else $error("outputs not idle after reset");
endmodule : km_properties

bind km_keying_mixer km_properties km_properties_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .keyedOutput(keyedOutput)
);
`default_nettype wire

// ### km_source_model.sv
// Purpose: peripherals and pins feeding the keying mixer
// Assumes: levels requested by the bench
// Notes:   slow mode adds one cycle of lag
`timescale 1ns/1ps
`default_nettype none
module km_source_model
  import km_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              slow,
  input wire logic [IN_NUM-1:0] want,
  output logic     [IN_NUM-1:0] lines
);
  logic [IN_NUM-1:0] lagFf;
  // every line registered once, with a second stage of lag in slow mode
  always_ff @(posedge ref_clk) begin
    lagFf <= want;
    lines <= slow ? lagFf : want;
  end
endmodule : km_source_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the keying mixer
// Assumes: sources steady while the pin is compared
// Notes:   random selections plus sync corner cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED at %0t: got %h expected %h", \
  $time, got, exp); end end
module testbench;
  import km_pkg::*;
  logic ref_clk = 1'h0, reset_n = 1'h0, slow = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] rsp;
  logic [IN_NUM-1:0] want = '0;
  logic [7:0] ctl, dsel, upc, loc;
  logic exp;
  wire logic awready, wready, bvalid, arready, rvalid, keyedOutput;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [IN_NUM-1:0] src;
  int n_errors = 0, n_compared = 0, cycles = 0, bLag = 0;

  km_source_model km_source_model_inst (.ref_clk(ref_clk), .slow(slow),
    .want(want), .lines(src));
  km_keying_mixer km_keying_mixer_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .captureCompareOne(src[IN_CAPTURE_COMPARE_ONE]), .captureCompareTwo(src[IN_CAPTURE_COMPARE_TWO]),
    .pulseGeneratorFive(src[IN_PULSE_GENERATOR_FIVE]), .pulseGeneratorSix(src[IN_PULSE_GENERATOR_SIX]),
    .serialPortOneDataOut(src[IN_SDO]),
    .serialPortOneSpiMode(src[IN_SPIM]), .comparatorOne(src[IN_CMP1]),
    .comparatorTwo(src[IN_CMP2]), .uartTransmitter(src[IN_UART]),
    .externalDataPin(src[IN_DPIN]), .numericOscillator(src[IN_NCO]),
    .logicCellOne(src[IN_LOGIC_CELL_ONE]), .logicCellTwo(src[IN_LOGIC_CELL_TWO]),
    .fastInternalOscillator(src[IN_FOSC]),
    .referenceClock(src[IN_REFC]), .externalCarrierPinA(src[IN_PINA]),
    .externalCarrierPinB(src[IN_PINB]), .keyedOutput(keyedOutput));

  always #5 ref_clk = ~ref_clk;

  task automatic print_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    awvalid <= 1'h1; awaddr <= a; wvalid <= 1'h1; wdata <= d;
    bready <= (bLag == 0);
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      k++;
      if (k >= bLag && !bready) bready <= 1'h1;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'h0;
    @(posedge ref_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int k = 0;
    arvalid <= 1'h1; araddr <= a; rready <= (bLag == 0);
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      k++;
      if (k >= bLag && !rready) rready <= 1'h1;
    end while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
    @(posedge ref_clk);
  endtask : axi_read

  task automatic pin(input int idx, input logic val);
    want[idx] <= val;
    repeat (6) @(posedge ref_clk);
  endtask : pin

  function automatic logic car(input logic [3:0] c, input logic [IN_NUM-1:0] v);
    case (c)
      CS_CAPTURE_COMPARE_ONE:  return v[IN_CAPTURE_COMPARE_ONE];
      CS_CAPTURE_COMPARE_TWO:  return v[IN_CAPTURE_COMPARE_TWO];
      CS_PULSE_GENERATOR_FIVE:  return v[IN_PULSE_GENERATOR_FIVE];
      CS_PULSE_GENERATOR_SIX:  return v[IN_PULSE_GENERATOR_SIX];
      CS_NCO:   return v[IN_NCO];
      CS_FOSC:  return v[IN_FOSC];
      CS_LOGIC_CELL_ONE:  return v[IN_LOGIC_CELL_ONE];
      CS_LOGIC_CELL_TWO:  return v[IN_LOGIC_CELL_TWO];
      CS_REFCK: return v[IN_REFC];
      CS_PINA:  return v[IN_PINA];
      CS_PINB:  return v[IN_PINB];
      default:  return 1'h0;
    endcase
  endfunction : car

  function automatic logic dat(input logic [3:0] c, input logic [IN_NUM-1:0] v,
                               input logic sw);
    case (c)
      DS_SOFT: return sw;
      DS_CAPTURE_COMPARE_ONE: return v[IN_CAPTURE_COMPARE_ONE];
      DS_CAPTURE_COMPARE_TWO: return v[IN_CAPTURE_COMPARE_TWO];
      DS_PULSE_GENERATOR_FIVE: return v[IN_PULSE_GENERATOR_FIVE];
      DS_PULSE_GENERATOR_SIX: return v[IN_PULSE_GENERATOR_SIX];
      DS_SDO:  return v[IN_SDO] & v[IN_SPIM];
      DS_CMP1: return v[IN_CMP1];
      DS_CMP2: return v[IN_CMP2];
      DS_UART: return v[IN_UART];
      DS_PIN:  return v[IN_DPIN];
      DS_NCO:  return v[IN_NCO];
      DS_LOGIC_CELL_ONE: return v[IN_LOGIC_CELL_ONE];
      DS_LOGIC_CELL_TWO: return v[IN_LOGIC_CELL_TWO];
      default: return 1'h0;
    endcase
  endfunction : dat

  function automatic logic expect_pin(input logic [IN_NUM-1:0] v,
    input logic [7:0] c, input logic [7:0] s, input logic [7:0] u,
    input logic [7:0] l);
    logic m;
    if (!c[CTL_ENABLE_BIT]) return 1'h0;
    m = dat(s[3:0], v, c[0]) ? car(u[3:0], v) ^ u[6] : car(l[3:0], v) ^ l[6];
    return m ^ c[CTL_OINV_BIT];
  endfunction : expect_pin

  initial begin
    rd = $urandom(94134);
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    for (int a = 0; a < 16; a += 4) begin
      axi_read(8'(a));
      `CHK(rd, 32'h0)
    end
    axi_read(8'h10);
    `CHK(rsp, RESP_SLVERR)
    axi_write(8'h10, 32'h000000FF);
    `CHK(rsp, RESP_SLVERR)
    wstrb <= 4'h0;
    axi_write(MIXER_CONTROL_OFS, 32'h000000FF);
    `CHK(rsp, RESP_OKAY)
    wstrb <= 4'hF;
    axi_read(MIXER_CONTROL_OFS);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 60; i++) begin
      dsel = {4'h0, 4'($urandom)};
      upc = {1'h0, 1'($urandom), 2'h0, 4'($urandom)};
      loc = {1'h0, 1'($urandom), 2'h0, 4'($urandom)};
      if (upc[3:0] == CS_SYSCK) upc[3:0] = CS_PINB;
      if (loc[3:0] == CS_SYSCK) loc[3:0] = CS_PINA;
      ctl = {1'(i % 4 != 0), 2'h0, 1'($urandom), 3'h0, 1'($urandom)};
      want <= IN_NUM'($urandom);
      bLag = $urandom % 4;
      slow <= 1'(i);
      axi_write(DATA_SOURCE_OFS, {24'h0, dsel});
      axi_write(UPPER_CARRIER_OFS, {24'h0, upc});
      axi_write(LOWER_CARRIER_OFS, {24'h0, loc});
      axi_write(MIXER_CONTROL_OFS, {24'h0, ctl});
      `CHK(rsp, RESP_OKAY)
      repeat (6) @(posedge ref_clk);
      exp = expect_pin(want, ctl, dsel, upc, loc);
      `CHK(keyedOutput, exp)
      axi_read(MIXER_CONTROL_OFS);
      `CHK(rd, {24'h0, ctl | {4'h0, exp, 3'h0}})
      axi_read(DATA_SOURCE_OFS);
      `CHK(rd, {24'h0, dsel})
      if (!ctl[CTL_ENABLE_BIT]) begin
        ctl[CTL_ENABLE_BIT] = 1'h1;
        axi_write(MIXER_CONTROL_OFS, {24'h0, ctl});
        repeat (6) @(posedge ref_clk);
        `CHK(keyedOutput, expect_pin(want, ctl, dsel, upc, loc))
      end
    end
    slow <= 1'h0;
    want <= '0;
    axi_write(UPPER_CARRIER_OFS, {24'h0, 4'h2, CS_PINA});
    axi_write(LOWER_CARRIER_OFS, {24'h0, 4'h0, CS_PINB});
    axi_write(DATA_SOURCE_OFS, {24'h0, 4'h0, DS_SOFT});
    axi_write(MIXER_CONTROL_OFS, 32'h00000080);
    pin(IN_PINA, 1'h1);
    pin(IN_PINA, 1'h0);
    pin(IN_PINA, 1'h1);
    axi_write(MIXER_CONTROL_OFS, 32'h00000081);
    repeat (6) @(posedge ref_clk);
    `CHK(keyedOutput, 1'h0)
    pin(IN_PINA, 1'h0);
    pin(IN_PINA, 1'h1);
    `CHK(keyedOutput, 1'h1)
    axi_write(MIXER_CONTROL_OFS, 32'h00000080);
    repeat (6) @(posedge ref_clk);
    `CHK(keyedOutput, 1'h1)
    pin(IN_PINA, 1'h0);
    `CHK(keyedOutput, 1'h0)
    axi_write(UPPER_CARRIER_OFS, {24'h0, 4'h0, CS_PINA});
    axi_write(LOWER_CARRIER_OFS, {24'h0, 4'h2, CS_PINB});
    pin(IN_PINB, 1'h1);
    axi_write(MIXER_CONTROL_OFS, 32'h00000081);
    repeat (6) @(posedge ref_clk);
    `CHK(keyedOutput, 1'h1)
    pin(IN_PINB, 1'h0);
    pin(IN_PINB, 1'h1);
    `CHK(keyedOutput, 1'h0)
    axi_write(MIXER_CONTROL_OFS, 32'h00000080);
    repeat (6) @(posedge ref_clk);
    `CHK(keyedOutput, 1'h0)
    pin(IN_PINB, 1'h0);
    pin(IN_PINB, 1'h1);
    `CHK(keyedOutput, 1'h1)
    pin(IN_PINB, 1'h0);
    axi_write(UPPER_CARRIER_OFS, {24'h0, 4'h0, CS_SYSCK});
    axi_write(MIXER_CONTROL_OFS, 32'h00000081);
    exp = keyedOutput;
    @(posedge ref_clk);
    `CHK(keyedOutput, ~exp)
    reset_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    `CHK(keyedOutput, 1'h0)
    axi_read(MIXER_CONTROL_OFS);
    `CHK(rd, 32'h0)
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
